// *** pkg/vic_map.svh ***
// Address map, field positions and fixed constants of the interrupt block
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH

`define VIC_AW 8
`define VIC_DW 32
`define VIC_NSRC 32
`define VIC_NEXT 6
`define VIC_VW 20

// Register offsets; the control registers fill 8'h80..8'hfc
`define VIC_OFF_FLAG 8'h00
`define VIC_OFF_VBASE 8'h04
`define VIC_OFF_STAT 8'h08
`define VIC_OFF_MASK 8'h0c
`define VIC_OFF_EDGE 8'h10
`define VIC_OFF_LVEC 8'h14
`define VIC_CTL_SEL 7

// Field positions
`define VIC_FLG_I 6
`define VIC_FLG_IPL 12
`define VIC_CTL_REQ 3

// Fixed vector table
`define VIC_VEC_UND 20'hfffdc
`define VIC_VEC_OVF 20'hfffe0
`define VIC_VEC_BRK 20'hfffe4
`define VIC_VEC_AM 20'hfffe8
`define VIC_VEC_STEP 20'hfffec
`define VIC_VEC_WDT 20'hffff0
`define VIC_VEC_DBC 20'hffff4
`define VIC_VEC_RES 20'hffffc
`define VIC_BRK_REDIRECT 8'hff
`define VIC_IPL_WDT 3'h7
`define VIC_IPL_RES 3'h0

// Special request slots
`define VIC_SP_AM 0
`define VIC_SP_STEP 1
`define VIC_SP_WDT 2
`define VIC_SP_DBC 3

// Status event bits
`define VIC_ST_MACC 0
`define VIC_ST_SPEC 1
`define VIC_ST_TRAP 2
`define VIC_ST_EDGE 3

// Source number of external pin i
`define VIC_EXT_NUM(i) (((i) < 3) ? (29 + (i)) : (4 + (i)))

`endif

// *** pkg/vic_pkg.sv ***
// Types shared by the interrupt block
`include "vic_map.svh"

package vic_pkg;

	typedef enum logic [0:0] {ST_BOOT, ST_RUN} phase_t;

	typedef enum logic [1:0] {TRAP_UND, TRAP_OVF, TRAP_BRK, TRAP_INT}
		trap_kind_t;

	typedef struct packed {
		phase_t                      phase;
		logic                        i_flag;
		logic [2:0]                  processor_priority_threshold;
		logic [`VIC_VW-1:0]          vbase;
		logic [`VIC_NSRC-1:0][3:0]   ctl;
		logic [3:0]                  stat;
		logic [3:0]                  mask;
		logic [`VIC_NEXT-1:0]        edge_pol;
		logic [3:0]                  spec;
		logic [`VIC_VW-1:0]          vec;
		logic                        vec_valid;
		logic                        pend;
		logic                        irq;
		logic [`VIC_DW-1:0]          rdata;
	} state_t;

	typedef struct packed {
		logic armed;
		logic prev;
		logic pulse;
	} edge_state_t;

endpackage

// *** pkg/arb_if.sv ***
// Carries pending requests to the resolver and the winner back
`timescale 1ns/10ps
`include "vic_map.svh"

interface arb_if;
	logic [`VIC_NSRC-1:0]      req;
	logic [`VIC_NSRC-1:0][2:0] lvl;
	logic                      i_flag;
	logic [2:0]                processor_priority_threshold;
	logic                      win;
	logic [4:0]                id;
	logic [2:0]                win_lvl;

	modport res (input req, lvl, i_flag, processor_priority_threshold, output win, id, win_lvl);
	modport top (output req, lvl, i_flag, processor_priority_threshold, input win, id, win_lvl);
endinterface

// *** rtl/ext_edge.sv ***
// Edge detector for one external request pin
`timescale 1ns/10ps

module ext_edge (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic pin,
	input  wire logic rising,
	output logic      pulse
);
	vic_pkg::edge_state_t s_q;
	vic_pkg::edge_state_t s_d;

	// No edge is reported on the first sample after reset
	always_comb begin
		s_d       = s_q;
		s_d.armed = 1'b1;
		s_d.prev  = pin;
		s_d.pulse = s_q.armed &
			(rising ? (pin & ~s_q.prev) : (~pin & s_q.prev));
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pulse = s_q.pulse;
endmodule // ext_edge

// *** rtl/prio_resolver.sv ***
// Picks the maskable request to accept
`timescale 1ns/10ps
`include "vic_map.svh"

module prio_resolver (
	arb_if.res a
);
	// Descending scan with >= lets the lower source number win a tie
	always_comb begin
		a.win     = 1'b0;
		a.id      = '0;
		a.win_lvl = '0;
		for (int i = `VIC_NSRC - 1; i >= 0; i--) begin
			if (a.i_flag && a.req[i] && (a.lvl[i] > a.processor_priority_threshold)
				&& (a.lvl[i] >= a.win_lvl)) begin
				a.win     = 1'b1;
				a.id      = 5'(i);
				a.win_lvl = a.lvl[i];
			end
		end
	end
endmodule // prio_resolver

// *** rtl/vectored_interrupt_controller.sv ***
// Vectored interrupt controller with fixed and relocatable vector tables
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`include "vic_map.svh"

module vectored_interrupt_controller #(
	parameter int NUM_SRC = `VIC_NSRC,
	parameter int NUM_EXT = `VIC_NEXT
) (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic [`VIC_AW-1:0]   addr,
	input  wire logic [`VIC_DW-1:0]   wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output logic [`VIC_DW-1:0]        rdata,
	input  wire logic [NUM_SRC-1:0]   periph_req,
	input  wire logic [NUM_EXT-1:0]   ext_pin,
	input  wire logic                 wdt_req,
	input  wire logic                 dbc_req,
	input  wire logic                 step_req,
	input  wire logic                 amatch_req,
	input  wire logic                 trap_valid,
	input  wire vic_pkg::trap_kind_t  trap_kind,
	input  wire logic [5:0]           trap_num,
	input  wire logic [7:0]           brk_vec_byte,
	input  wire logic                 take,
	output logic                      int_pend,
	output logic [`VIC_VW-1:0]        vec_addr,
	output logic                      vec_valid,
	output logic                      i_flag,
	output logic [2:0]                processor_priority_threshold,
	output logic                      irq
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// The state record is sized by the map, so other counts cannot fit
	if (NUM_SRC != `VIC_NSRC || NUM_EXT != `VIC_NEXT) begin : g_bad
		$error("vectored_interrupt_controller: unsupported size");
	end

	localparam vic_pkg::state_t RST_STATE = '{
		phase:  vic_pkg::ST_BOOT,
		default: '0
	};

	vic_pkg::state_t      s_q;
	vic_pkg::state_t      s_d;
	logic [NUM_EXT-1:0]   ext_pulse;
	logic [NUM_SRC-1:0]   ext_set;
	logic [NUM_SRC-1:0]   set_vec;
	logic [4:0]           ctl_idx;

	arb_if arb ();

	// ****************************************************************
	// External edge requests
	// ****************************************************************
	for (genvar g = 0; g < NUM_EXT; g++) begin : g_ext
		ext_edge u_edge (
			.clk    (clk),
			.arst_n (arst_n),
			.pin    (ext_pin[g]),
			.rising (s_q.edge_pol[g]),
			.pulse  (ext_pulse[g])
		);
	end

	always_comb begin
		ext_set = '0;
		for (int i = 0; i < NUM_EXT; i++) begin
			ext_set[`VIC_EXT_NUM(i)] = ext_pulse[i];
		end
	end

	assign set_vec = periph_req | ext_set;
	assign ctl_idx = addr[6:2];

	// ****************************************************************
	// Arbitration among maskable sources
	// ****************************************************************
	for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
		assign arb.req[g] = s_q.ctl[g][`VIC_CTL_REQ];
		assign arb.lvl[g] = s_q.ctl[g][2:0];
	end
	assign arb.i_flag = s_q.i_flag;
	assign arb.processor_priority_threshold    = s_q.processor_priority_threshold;

	prio_resolver u_res (
		.a (arb.res)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [3:0]         ev;
		logic [3:0]         w1c;
		logic [`VIC_VW-1:0] rel;
		ev  = '0;
		w1c = '0;
		rel = s_q.vbase + `VIC_VW'({trap_num, 2'b00});
		s_d = s_q;
		s_d.vec_valid = 1'b0;
		s_d.rdata     = '0;

		// Register writes
		if (wr) begin
			if (addr[`VIC_CTL_SEL]) begin
				s_d.ctl[ctl_idx][2:0] = wdata[2:0];
				s_d.ctl[ctl_idx][`VIC_CTL_REQ] =
					s_q.ctl[ctl_idx][`VIC_CTL_REQ] &
					wdata[`VIC_CTL_REQ];
			end else begin
				case (addr)
					`VIC_OFF_FLAG: begin
						s_d.i_flag = wdata[`VIC_FLG_I];
						s_d.processor_priority_threshold    = wdata[`VIC_FLG_IPL +: 3];
					end
					`VIC_OFF_VBASE: begin
						s_d.vbase = wdata[`VIC_VW-1:0];
					end
					`VIC_OFF_STAT: begin
						w1c = wdata[3:0];
					end
					`VIC_OFF_MASK: begin
						s_d.mask = wdata[3:0];
					end
					`VIC_OFF_EDGE: begin
						s_d.edge_pol = wdata[NUM_EXT-1:0];
					end
					default: begin
					end
				endcase
			end
		end

		// Register reads, answered in the next cycle
		if (rd) begin
			if (addr[`VIC_CTL_SEL]) begin
				s_d.rdata[3:0] = s_q.ctl[ctl_idx];
			end else begin
				case (addr)
					`VIC_OFF_FLAG: begin
						s_d.rdata[`VIC_FLG_I] = s_q.i_flag;
						s_d.rdata[`VIC_FLG_IPL +: 3] = s_q.processor_priority_threshold;
					end
					`VIC_OFF_VBASE: begin
						s_d.rdata[`VIC_VW-1:0] = s_q.vbase;
					end
					`VIC_OFF_STAT: begin
						s_d.rdata[3:0] = s_q.stat;
					end
					`VIC_OFF_MASK: begin
						s_d.rdata[3:0] = s_q.mask;
					end
					`VIC_OFF_EDGE: begin
						s_d.rdata[NUM_EXT-1:0] = s_q.edge_pol;
					end
					`VIC_OFF_LVEC: begin
						s_d.rdata[`VIC_VW-1:0] = s_q.vec;
					end
					default: begin
					end
				endcase
			end
		end

		// Vector sequencing; a threshold set on acceptance overrides a same-cycle flag write of the threshold, not of i_flag
		unique case (s_q.phase)
			vic_pkg::ST_BOOT: begin
				s_d.vec       = `VIC_VEC_RES;
				s_d.vec_valid = 1'b1;
				s_d.processor_priority_threshold       = `VIC_IPL_RES;
				s_d.phase     = vic_pkg::ST_RUN;
			end
			vic_pkg::ST_RUN: begin
				if (trap_valid) begin
					// Traps never consult the mask flag or threshold
					ev[`VIC_ST_TRAP] = 1'b1;
					s_d.vec_valid    = 1'b1;
					unique case (trap_kind)
						vic_pkg::TRAP_UND: s_d.vec = `VIC_VEC_UND;
						vic_pkg::TRAP_OVF: s_d.vec = `VIC_VEC_OVF;
						vic_pkg::TRAP_BRK: begin
							if (brk_vec_byte == `VIC_BRK_REDIRECT) begin
								s_d.vec = s_q.vbase;
							end else begin
								s_d.vec = `VIC_VEC_BRK;
							end
						end
						vic_pkg::TRAP_INT: s_d.vec = rel;
					endcase
				end else if (take) begin
					if (s_q.spec[`VIC_SP_DBC]) begin
						s_d.spec[`VIC_SP_DBC] = 1'b0;
						s_d.vec = `VIC_VEC_DBC;
						s_d.vec_valid = 1'b1;
						ev[`VIC_ST_SPEC] = 1'b1;
					end else if (s_q.spec[`VIC_SP_WDT]) begin
						s_d.spec[`VIC_SP_WDT] = 1'b0;
						s_d.vec = `VIC_VEC_WDT;
						s_d.processor_priority_threshold = `VIC_IPL_WDT;
						s_d.vec_valid = 1'b1;
						ev[`VIC_ST_SPEC] = 1'b1;
					end else if (arb.win) begin
						s_d.ctl[arb.id][`VIC_CTL_REQ] = 1'b0;
						s_d.vec = s_q.vbase +
							`VIC_VW'({arb.id, 2'b00});
						s_d.processor_priority_threshold = arb.win_lvl;
						s_d.vec_valid = 1'b1;
						ev[`VIC_ST_MACC] = 1'b1;
					end else if (s_q.spec[`VIC_SP_STEP]) begin
						s_d.spec[`VIC_SP_STEP] = 1'b0;
						s_d.vec = `VIC_VEC_STEP;
						s_d.vec_valid = 1'b1;
						ev[`VIC_ST_SPEC] = 1'b1;
					end else if (s_q.spec[`VIC_SP_AM]) begin
						s_d.spec[`VIC_SP_AM] = 1'b0;
						s_d.vec = `VIC_VEC_AM;
						s_d.vec_valid = 1'b1;
						ev[`VIC_ST_SPEC] = 1'b1;
					end
				end
			end
		endcase

		// Hardware sets come last so a new request beats any clear
		for (int i = 0; i < NUM_SRC; i++) begin
			if (set_vec[i]) begin
				s_d.ctl[i][`VIC_CTL_REQ] = 1'b1;
			end
		end
		s_d.spec = s_d.spec |
			{dbc_req, wdt_req, step_req, amatch_req};

		ev[`VIC_ST_EDGE] = |ext_pulse;
		s_d.stat = (s_q.stat & ~w1c) | ev;
		s_d.irq  = |(s_d.stat & s_d.mask);
		// Pending view lags the request bits by one cycle
		s_d.pend = arb.win | (|s_q.spec);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= RST_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign rdata     = s_q.rdata;
	assign int_pend  = s_q.pend;
	assign vec_addr  = s_q.vec;
	assign vec_valid = s_q.vec_valid;
	assign i_flag    = s_q.i_flag;
	assign processor_priority_threshold       = s_q.processor_priority_threshold;
	assign irq       = s_q.irq;

endmodule // vectored_interrupt_controller

// *** tb/vic_checker.sv ***
// Port assertions for the vectored interrupt controller
`timescale 1ns/10ps

module vic_checker #(
	parameter int NUM_SRC = 32,
	parameter int NUM_EXT = 6
) (
	input wire logic                clk,
	input wire logic                arst_n,
	input wire logic [7:0]          addr,
	input wire logic                wr,
	input wire logic                rd,
	input wire logic [31:0]         rdata,
	input wire logic                trap_valid,
	input wire vic_pkg::trap_kind_t trap_kind,
	input wire logic [7:0]          brk_vec_byte,
	input wire logic                take,
	input wire logic [19:0]         vec_addr,
	input wire logic                vec_valid,
	input wire logic                i_flag,
	input wire logic [2:0]          processor_priority_threshold
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic run_q;
	// Boot vector cycle ignores traps, so antecedents skip it
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			run_q <= 1'b0;
		else
			run_q <= 1'b1;
	sequence trp(k);
		run_q && trap_valid && !wr && trap_kind == k;
	endsequence
	chk_und_vec: assert property (trp(vic_pkg::TRAP_UND)
		|=> vec_valid && vec_addr == 20'hfffdc) else $error("und vector");
	chk_ovf_vec: assert property (trp(vic_pkg::TRAP_OVF)
		|=> vec_valid && vec_addr == 20'hfffe0) else $error("ovf vector");
	chk_brk_fixed: assert property (run_q && trap_valid && !wr
		&& trap_kind == vic_pkg::TRAP_BRK && brk_vec_byte != 8'hff
		|=> vec_addr == 20'hfffe4)
		else $error("brk vector");
	chk_trap_ipl: assert property (run_q && trap_valid && !wr
		|=> vec_valid && processor_priority_threshold == $past(processor_priority_threshold)) else $error("trap ipl");
	chk_vec_cause: assert property (vec_valid |-> $past(take)
		|| $past(trap_valid) || vec_addr == 20'hffffc)
		else $error("vector without cause");
	chk_take_ipl: assert property (vec_valid && $past(take)
		&& !$past(trap_valid) |-> processor_priority_threshold >= $past(processor_priority_threshold))
		else $error("ipl fell on accept");
	chk_ipl_cause: assert property ($changed(processor_priority_threshold)
		|-> $past(take) || $past(wr)) else $error("ipl side effect");
	chk_flag_cause: assert property ($changed(i_flag)
		|-> $past(wr) && $past(addr) == 8'h00) else $error("flag change");
	chk_ctl_zero: assert property ($past(rd) && $past(addr) >= 8'h80
		|-> rdata[31:4] == 28'h0) else $error("ctl upper bits");
	cov_trap: cover property (trp(vic_pkg::TRAP_INT));
	cov_take: cover property (take ##1 vec_valid);
	cov_ipl7: cover property (vec_valid && processor_priority_threshold == 3'h7);
endmodule // vic_checker

// *** tb/cpu_model.sv ***
// CPU side: accepts whatever the controller flags as pending
`timescale 1ns/10ps

module cpu_model (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic en,
	input  wire logic int_pend,
	output logic      take
);
	logic [1:0] gap_q;
	// Gap lets the registered pending flag settle before the next take
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			take  <= 1'b0;
			gap_q <= 2'h0;
		end else if (gap_q != 2'h0) begin
			take  <= 1'b0;
			gap_q <= gap_q - 2'h1;
		end else begin
			take  <= en && int_pend;
			gap_q <= {2{en && int_pend}};
		end
	end
endmodule // cpu_model

// *** tb/vectored_interrupt_controller_tb.sv ***
// Bench for the vectored interrupt controller
`timescale 1ns/10ps

module vectored_interrupt_controller_tb;
	logic                clk, arst_n, wr, rd, trap_valid, take, take_en;
	logic                wdt_req, dbc_req, step_req, amatch_req, int_pend;
	logic                vec_valid, i_flag, irq;
	logic [7:0]          addr, brk_vec_byte;
	logic [31:0]         wdata, rdata, periph_req;
	logic [5:0]          ext_pin, trap_num;
	logic [19:0]         vec_addr;
	logic [2:0]          processor_priority_threshold;
	vic_pkg::trap_kind_t trap_kind;
	int                  fail_count, cmp_count, cyc;

	vectored_interrupt_controller i_dut (.clk, .arst_n, .addr, .wdata, .wr,
		.rd, .rdata, .periph_req, .ext_pin, .wdt_req, .dbc_req, .step_req,
		.amatch_req, .trap_valid, .trap_kind, .trap_num, .brk_vec_byte,
		.take, .int_pend, .vec_addr, .vec_valid, .i_flag, .processor_priority_threshold, .irq);
	cpu_model i_cpu (.clk, .arst_n, .en(take_en), .int_pend, .take);

	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	function automatic logic [31:0] fw(input logic i, input logic [2:0] l);
		return (32'(l) << 12) | (32'(i) << 6);
	endfunction
	task automatic trap(input vic_pkg::trap_kind_t k, input logic [5:0] n,
		input logic [19:0] e);
		@(posedge clk);
		trap_valid <= 1'b1;
		trap_kind  <= k;
		trap_num   <= n;
		@(posedge clk);
		trap_valid <= 1'b0;
		#1 chk(32'(vec_addr), 32'(e));
		chk(32'(processor_priority_threshold), 32'h0);
	endtask
	task automatic wait_vec(input logic [19:0] a, input logic [2:0] l);
		int n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (vec_valid !== 1'b1 && n < 20);
		chk(32'(vec_addr), 32'(a));
		chk(32'(processor_priority_threshold), 32'(l));
	endtask
	task automatic no_vec();
		repeat (10) begin
			@(posedge clk);
			#1 chk(32'(vec_valid), 32'h0);
		end
	endtask
	task automatic pulse(input logic [31:0] m);
		@(posedge clk);
		periph_req <= m;
		@(posedge clk);
		periph_req <= 32'h0;
	endtask

	// ***
	// Scenarios
	// ***
	task automatic t_traps();
		wr_reg(8'h04, 32'h12340);
		wr_reg(8'h0c, 32'h4);
		trap(vic_pkg::TRAP_UND, 6'h0, 20'hfffdc);
		trap(vic_pkg::TRAP_OVF, 6'h0, 20'hfffe0);
		trap(vic_pkg::TRAP_BRK, 6'h0, 20'hfffe4);
		@(posedge clk);
		brk_vec_byte <= 8'hff;
		trap(vic_pkg::TRAP_BRK, 6'h0, 20'h12340);
		trap(vic_pkg::TRAP_INT, 6'h28, 20'h123e0);
		trap(vic_pkg::TRAP_INT, 6'h3f, 20'h1243c);
		@(posedge clk);
		#1 chk(32'(irq), 32'h1);
		wr_reg(8'h08, 32'hf);
		@(posedge clk);
		#1 chk(32'(irq), 32'h0);
	endtask
	task automatic t_accept();
		wr_reg(8'hd4, 32'h3);
		pulse(32'h0020_0000);
		rd_reg(8'hd4, 32'hb);
		@(posedge clk);
		take_en <= 1'b1;
		no_vec();
		wr_reg(8'h00, fw(1'b1, 3'h0));
		wait_vec(20'h12394, 3'h3);
		rd_reg(8'hd4, 32'h3);
		rd_reg(8'h00, fw(1'b1, 3'h3));
		chk(32'(i_flag), 32'h1);
	endtask
	task automatic t_levels();
		wr_reg(8'h00, fw(1'b0, 3'h2));
		wr_reg(8'hd8, 32'h3);
		pulse(32'h0060_0000);
		wr_reg(8'h00, fw(1'b1, 3'h2));
		wait_vec(20'h12394, 3'h3);
		no_vec();
		wr_reg(8'h00, fw(1'b0, 3'h3));
		wr_reg(8'hd8, 32'hf);
		wr_reg(8'h00, fw(1'b1, 3'h7));
		no_vec();
		wr_reg(8'h00, fw(1'b1, 3'h6));
		wait_vec(20'h12398, 3'h7);
	endtask
	task automatic t_clear();
		wr_reg(8'h00, fw(1'b0, 3'h0));
		wr_reg(8'h94, 32'h9);
		rd_reg(8'h94, 32'h1);
		pulse(32'h20);
		rd_reg(8'h94, 32'h9);
		chk(32'(int_pend), 32'h0);
		wr_reg(8'h94, 32'h1);
		rd_reg(8'h94, 32'h1);
		rd_reg(8'h40, 32'h0);
	endtask
	task automatic t_edge();
		@(posedge clk);
		ext_pin[3] <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(8'h9c, 32'h0);
		@(posedge clk);
		ext_pin[3] <= 1'b0;
		repeat (3) @(posedge clk);
		rd_reg(8'h9c, 32'h8);
		wr_reg(8'h9c, 32'h0);
		wr_reg(8'h10, 32'h8);
		@(posedge clk);
		ext_pin[3] <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(8'h9c, 32'h8);
	endtask
	task automatic t_wdt();
		@(posedge clk);
		wdt_req <= 1'b1;
		take_en <= 1'b0;
		@(posedge clk);
		wdt_req <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(32'(int_pend), 32'h1);
		@(posedge clk);
		take_en <= 1'b1;
		wait_vec(20'hffff0, 3'h7);
	endtask
	task automatic t_spec();
		@(posedge clk);
		{dbc_req, step_req, amatch_req} <= 3'h7;
		@(posedge clk);
		{dbc_req, step_req, amatch_req} <= 3'h0;
		wait_vec(20'hffff4, 3'h7);
		wait_vec(20'hfffec, 3'h7);
		wait_vec(20'hfffe8, 3'h7);
	endtask

	initial begin
		{clk, arst_n, wr, rd, trap_valid, take_en, wdt_req} = 7'h0;
		{dbc_req, step_req, amatch_req} = 3'h0;
		{addr, brk_vec_byte, wdata, periph_req} = 80'h0;
		{ext_pin, trap_num, trap_kind} = 14'h0;
		{fail_count, cmp_count, cyc} = 96'h0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		#1 chk(32'(vec_addr), 32'hffffc);
		rd_reg(8'h00, 32'h0);
		t_traps();
		t_accept();
		t_levels();
		t_clear();
		t_edge();
		t_wdt();
		t_spec();
		stop_test();
	end
endmodule // vectored_interrupt_controller_tb

bind vectored_interrupt_controller vic_checker #(.NUM_SRC(NUM_SRC),
	.NUM_EXT(NUM_EXT)) i_chk (.clk, .arst_n, .addr, .wr, .rd, .rdata,
	.trap_valid, .trap_kind, .brk_vec_byte, .take, .vec_addr, .vec_valid,
	.i_flag, .processor_priority_threshold);
